// file: inc/serial_element_params.svh
`ifndef SERIAL_ELEMENT_PARAMS_SVH
`define SERIAL_ELEMENT_PARAMS_SVH

// Register byte addresses on the APB side
`define OFS_MODEM_CTRL 8'h00
`define OFS_FIFO_CTRL 8'h04
`define OFS_MODEM_STAT 8'h08
`define OFS_INT_STAT 8'h0c
`define OFS_INT_MASK 8'h10
`define OFS_RX_TRIGGER 8'h14

// Word indices seen on the strobe-qualified parallel port
`define IDX_MODEM_CTRL 3'h0
`define IDX_FIFO_CTRL 3'h1
`define IDX_MODEM_STAT 3'h2
`define IDX_INT_STAT 3'h3
`define IDX_INT_MASK 3'h4
`define IDX_RX_TRIGGER 3'h5

// Modem control fields
`define MC_RTS_BIT 1
`define MC_LOOP_BIT 4
`define MC_AUTO_RTS_BIT 5
`define MC_WMASK 8'h32

// FIFO control fields
`define FC_FIFO_EN_BIT 0
`define FC_DMA_SEL_BIT 3
`define FC_WMASK 8'h09

// Modem status fields
`define MS_RING_EDGE_BIT 2
`define MS_RING_LEVEL_BIT 6

// Interrupt status and mask field
`define INT_RING_BIT 0
`define INT_WMASK 8'h01

// Reset values
`define RST_BYTE 8'h00
`define RST_TRIGGER 7'h01
`define RST_SYNC 7'h05

`endif

// file: inc/serial_element_pkg.sv
package serial_element_pkg;
   // One byte of register content
   typedef logic [7:0] byte_t;
   // One APB data word
   typedef logic [31:0] word_t;
   // Receive DMA signalling style
   typedef enum logic {dma_single, dma_multi} dma_mode_t;
endpackage : serial_element_pkg

// file: rtl/serial_element_modem.sv
// Function
// - Selected read strobe drives addressed register out
// - Modem status bit 6 shows ring level
// - Modem status bit 2 flags ring rise
// - Ring rise raises interrupt when enabled
// - Control bit 1 set drives request low
// - Request high after reset, loopback, bit clear
// - Auto mode with FIFO enabled: threshold logic drives request high
// - Auto mode: request low below threshold
// - FIFO mode: bit 3 picks DMA style
// - Character mode uses single-transfer DMA only
// - Mode 0 request low while data held
// - Mode 0 request high when empty
// - Mode 1 request low at trigger/timeout
// - Mode 1 request held low until empty
`timescale 1ns/1ns
`include "serial_element_params.svh"

module serial_element_modem #(
   parameter int CNT_W = 7 // Width of the receive fill count
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chip_select,
   input wire logic read_strobe_low,
   input wire logic read_strobe_high,
   input wire logic [2:0] reg_sel,
   output logic [7:0] data_out,
   output logic data_oe_n,
   input wire logic ring_indicator_in,
   output logic rts_n,
   input wire logic [CNT_W-1:0] rx_count,
   input wire logic rx_timeout,
   output logic receive_dma_request,
   output logic irq
);

   // Software state
   serial_element_pkg::byte_t modem_control_reg_r; // Flow control bits
   serial_element_pkg::byte_t fifo_ctrl_r; // FIFO and DMA bits
   serial_element_pkg::byte_t int_stat_r; // Sticky event bits
   serial_element_pkg::byte_t int_mask_r; // Interrupt enables
   logic [CNT_W-1:0] rx_trigger_r; // Fill threshold
   logic ring_trailing_edge_flag_r; // Rise seen since last read
   logic ring_prev_r; // Ring level one cycle ago

   // Output flops
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [7:0] data_out_r;
   logic data_oe_n_r;
   logic rts_n_r;
   logic rx_req_n_r;
   logic irq_r;
   logic pin_rd_prev_r; // Strobe read active last cycle

   // Pin synchronisers: ring, cs, strobe low, strobe high, index
   localparam int SYNC_W = 7; // Four single pins plus the index
   // Idle pin levels, so no false read or ring edge follows reset
   localparam logic [SYNC_W-1:0] SYNC_RST = `RST_SYNC;
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;

   assign pins_raw = {reg_sel, read_strobe_high, read_strobe_low,
                      chip_select, ring_indicator_in};

   // Two flops per pin; only the second stage feeds logic
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_r[gi] <= SYNC_RST[gi];
               sync2_r[gi] <= SYNC_RST[gi];
            end else begin
               sync1_r[gi] <= pins_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   // Synchronised pin views
   wire ring_s = sync2_r[0];
   wire cs_s = sync2_r[1];
   wire rdl_s = sync2_r[2];
   wire rdh_s = sync2_r[3];
   wire [2:0] idx_s = sync2_r[6:4];

   // either strobe qualifies; the idle one is held inactive
   // nothing happens unless chip select is high
   wire pin_rd = cs_s & (~rdl_s | rdh_s);
   wire pin_rd_start = pin_rd & ~pin_rd_prev_r;

   // APB phase decode: one wait state, transfer ends on pready_r
   wire apb_access = psel & penable;
   wire apb_done = apb_access & pready_r;
   wire apb_wr = apb_done & pwrite;
   wire apb_rd_first = apb_access & ~pready_r & ~pwrite;

   // Address decode
   wire hit_mc = (paddr == `OFS_MODEM_CTRL);
   wire hit_fc = (paddr == `OFS_FIFO_CTRL);
   wire hit_ms = (paddr == `OFS_MODEM_STAT);
   wire hit_is = (paddr == `OFS_INT_STAT);
   wire hit_im = (paddr == `OFS_INT_MASK);
   wire hit_tr = (paddr == `OFS_RX_TRIGGER);
   wire hit_any = hit_mc | hit_fc | hit_ms | hit_is | hit_im | hit_tr;

   // live ring level next to the edge flag
   serial_element_pkg::byte_t modem_stat;
   always_comb begin
      modem_stat = `RST_BYTE;
      modem_stat[`MS_RING_LEVEL_BIT] = ring_s;
      modem_stat[`MS_RING_EDGE_BIT] = ring_trailing_edge_flag_r;
   end

   // Trigger widened to a byte for readback
   serial_element_pkg::byte_t trig_byte;
   always_comb begin
      trig_byte = `RST_BYTE;
      trig_byte[CNT_W-1:0] = rx_trigger_r;
   end

   // Read multiplexers, one per access path
   serial_element_pkg::byte_t apb_rd_byte;
   assign apb_rd_byte = hit_mc ? modem_control_reg_r :
                        hit_fc ? fifo_ctrl_r :
                        hit_ms ? modem_stat :
                        hit_is ? int_stat_r :
                        hit_im ? int_mask_r :
                        hit_tr ? trig_byte : `RST_BYTE;

   serial_element_pkg::byte_t pin_rd_byte;
   assign pin_rd_byte =
      (idx_s == `IDX_MODEM_CTRL) ? modem_control_reg_r :
      (idx_s == `IDX_FIFO_CTRL) ? fifo_ctrl_r :
      (idx_s == `IDX_MODEM_STAT) ? modem_stat :
      (idx_s == `IDX_INT_STAT) ? int_stat_r :
      (idx_s == `IDX_INT_MASK) ? int_mask_r :
      (idx_s == `IDX_RX_TRIGGER) ? trig_byte : `RST_BYTE;

   // Reads of modem status that clear the edge flag
   wire ms_rd_apb = apb_done & ~pwrite & hit_ms;
   wire ms_rd_pin = pin_rd_start & (idx_s == `IDX_MODEM_STAT);
   wire ms_read = ms_rd_apb | ms_rd_pin;

   // Ring edge detection on the synchronised level
   wire ring_rise = ring_s & ~ring_prev_r;

   // Write-one-to-clear of interrupt status
   serial_element_pkg::byte_t is_clr;
   assign is_clr = (apb_wr & hit_is) ?
                   (pwdata[7:0] & `INT_WMASK) : `RST_BYTE;

   // Hardware-set events, aligned to status layout
   serial_element_pkg::byte_t is_set;
   always_comb begin
      is_set = `RST_BYTE;
      is_set[`INT_RING_BIT] = ring_rise;
   end

   // DMA style selection
   wire fifo_en = fifo_ctrl_r[`FC_FIFO_EN_BIT];
   // bit 3 picks the style in FIFO mode
   // character mode is forced to single transfer
   serial_element_pkg::dma_mode_t dma_mode;
   assign dma_mode = (fifo_en & fifo_ctrl_r[`FC_DMA_SEL_BIT]) ?
                     serial_element_pkg::dma_multi :
                     serial_element_pkg::dma_single;

   // Receive fill status
   wire rx_empty = (rx_count == '0);
   wire rx_at_trig = (rx_count >= rx_trigger_r);

   // Receive DMA request next value
   logic rx_req_n_nxt;
   always_comb begin
      rx_req_n_nxt = rx_req_n_r;
      unique case (dma_mode)
         serial_element_pkg::dma_single: begin
            // low while anything held, high when empty
            rx_req_n_nxt = rx_empty;
         end
         serial_element_pkg::dma_multi: begin
            if (rx_empty) begin
               rx_req_n_nxt = 1'b1;
            end else if (rx_at_trig | rx_timeout) begin
               rx_req_n_nxt = 1'b0;
            end
         end
      endcase
   end

   // Request-to-send next value
   wire rts_bit = modem_control_reg_r[`MC_RTS_BIT];
   wire loop_on = modem_control_reg_r[`MC_LOOP_BIT];
   wire auto_rts = modem_control_reg_r[`MC_AUTO_RTS_BIT];
   logic rts_n_nxt;
   always_comb begin
      if (loop_on | ~rts_bit) begin
         // inactive in loopback or with the bit cleared
         rts_n_nxt = 1'b1;
      end else if (auto_rts & fifo_en) begin
         rts_n_nxt = ~rx_empty & rx_at_trig;
      end else begin
         rts_n_nxt = 1'b0;
      end
   end

   // Control registers written from APB
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_control_reg_r <= `RST_BYTE;
         fifo_ctrl_r <= `RST_BYTE;
         int_mask_r <= `RST_BYTE;
         rx_trigger_r <= `RST_TRIGGER;
      end else if (apb_wr) begin
         if (hit_mc) begin
            modem_control_reg_r <= pwdata[7:0] & `MC_WMASK;
         end
         if (hit_fc) begin
            fifo_ctrl_r <= pwdata[7:0] & `FC_WMASK;
         end
         if (hit_im) begin
            int_mask_r <= pwdata[7:0] & `INT_WMASK;
         end
         if (hit_tr) begin
            rx_trigger_r <= pwdata[CNT_W-1:0];
         end
      end
   end

   // Ring edge flag and sticky status; a new event beats a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ring_prev_r <= 1'b1;
         ring_trailing_edge_flag_r <= 1'b0;
         int_stat_r <= `RST_BYTE;
      end else begin
         ring_prev_r <= ring_s;
         // set on rise, cleared by a status read
         ring_trailing_edge_flag_r <= ring_rise |
            (ring_trailing_edge_flag_r & ~ms_read);
         // ring rise latches an interrupt event
         int_stat_r <= is_set | (int_stat_r & ~is_clr);
      end
   end

   // APB answer: pready one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= apb_access & ~pready_r;
         pslverr_r <= apb_access & ~pready_r & ~hit_any;
         if (apb_rd_first) begin
            prdata_r <= {24'h000000, apb_rd_byte};
         end
      end
   end

   // strobe read drives the addressed byte, enable low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_rd_prev_r <= 1'b0;
         data_out_r <= `RST_BYTE;
         data_oe_n_r <= 1'b1;
      end else begin
         pin_rd_prev_r <= pin_rd;
         data_oe_n_r <= ~pin_rd;
         // Byte captured at read start so a clearing read
         // still shows the flag it clears
         if (pin_rd_start) begin
            data_out_r <= pin_rd_byte;
         end
      end
   end

   // Modem-side and interrupt outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rts_n_r <= 1'b1;
         rx_req_n_r <= 1'b1;
         irq_r <= 1'b0;
      end else begin
         rts_n_r <= rts_n_nxt;
         rx_req_n_r <= rx_req_n_nxt;
         irq_r <= |(int_stat_r & int_mask_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign data_out = data_out_r;
   assign data_oe_n = data_oe_n_r;
   assign rts_n = rts_n_r;
   assign receive_dma_request = rx_req_n_r;
   assign irq = irq_r;

endmodule : serial_element_modem

// file: tb/modem_sva.sv
`timescale 1ns/1ns
module modem_sva #(
   parameter int CNT_W = 7 // Receive fill count width
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chip_select,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   input wire logic [CNT_W-1:0] rx_count,
   input wire logic receive_dma_request
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // First access cycle of an APB transfer
   sequence acc_s;
      psel && $rose(penable);
   endsequence
   // Chip deselected long enough to pass the synchroniser
   sequence cs_off_s;
      !chip_select [*4];
   endsequence
   pready_wait_a: assert property (acc_s |=> pready)
      else $error("apb answer late");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_decode_a: assert property (pready && paddr[1:0] == 2'h0
      |-> pslverr == (paddr > 8'h14)) else $error("bad decode error");
   err_alone_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_upper_a: assert property (pready && !pwrite
      |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   dma_empty_a: assert property (rx_count == '0 |=> receive_dma_request)
      else $error("dma request while empty");
   oe_idle_a: assert property (cs_off_s |=> data_oe_n)
      else $error("bus driven while deselected");
   oe_cause_a: assert property (!data_oe_n |-> $past(chip_select, 3))
      else $error("drive without select");
   dout_hold_a: assert property (!data_oe_n && $past(!data_oe_n)
      |-> $stable(data_out)) else $error("read byte changed mid read");
endmodule : modem_sva

// file: tb/strobe_host.sv
`timescale 1ns/1ns
module strobe_host (
   input wire logic pclk,
   output logic chip_select,
   output logic read_strobe_low,
   output logic read_strobe_high,
   output logic [2:0] reg_sel,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n
);
   initial begin
      chip_select = 1'b0;
      read_strobe_low = 1'b1;
      read_strobe_high = 1'b0;
      reg_sel = 3'h0;
   end
   task automatic rd(input logic hi, cs, input logic [2:0] idx,
         output logic [7:0] d, output logic drove);
      int i;
      drove = 1'b0;
      d = 8'h00;
      @(posedge pclk);
      chip_select <= cs;
      reg_sel <= idx;
      if (hi) read_strobe_high <= 1'b1;
      else read_strobe_low <= 1'b0;
      // Only a driven bus is sampled; a floating bus means nothing
      for (i = 0; i < 8 && !drove; i++) begin
         @(posedge pclk);
         if (data_oe_n === 1'b0) begin
            drove = 1'b1;
            d = data_out;
         end
      end
      chip_select <= 1'b0;
      read_strobe_low <= 1'b1;
      read_strobe_high <= 1'b0;
      repeat (5) @(posedge pclk);
   endtask : rd
endmodule : strobe_host

// file: tb/tb_top.sv
`timescale 1ns/1ns
`include "serial_element_params.svh"
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, chip_select, read_strobe_low, read_strobe_high;
   logic [2:0] reg_sel;
   logic [7:0] data_out;
   logic data_oe_n, rts_n, receive_dma_request, irq;
   logic ring_indicator_in = 0, rx_timeout = 0;
   logic [6:0] rx_count = 7'h00;
   int num_errors = 0, n_checks = 0;
   logic [7:0] lf = 8'h38; // Random state, fixed seed
   always #4 pclk = ~pclk;
   serial_element_modem #(.CNT_W(7)) serial_element_modem_inst (.pclk,
      .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .chip_select, .read_strobe_low, .read_strobe_high, .reg_sel,
      .data_out, .data_oe_n, .ring_indicator_in, .rts_n, .rx_count,
      .rx_timeout, .receive_dma_request, .irq);
   strobe_host strobe_host_inst (.pclk, .chip_select, .read_strobe_low,
      .read_strobe_high, .reg_sel, .data_out, .data_oe_n);
   task give_verdict;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] g, e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic rnd(output logic [7:0] v);
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      v = lf;
   endtask : rnd
   // One APB transfer; an idle cycle precedes every setup
   task automatic apb(input logic w, input logic [7:0] a, wd,
         output logic [7:0] r, output logic er);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 9; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 9) begin
         num_errors++;
         give_verdict();
      end
      r = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rdc(input logic [7:0] a, x);
      logic [7:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk(r, x);
   endtask : rdc
   // Apply receive side inputs, then let outputs settle
   task automatic put(input logic [7:0] c, input logic to);
      @(posedge pclk);
      rx_count <= c[6:0];
      rx_timeout <= to;
      repeat (4) @(negedge pclk);
   endtask : put
   // Expected DMA request; held value only in multi mode
   function automatic logic edma(input logic p, input logic [7:0] f, c, t,
         input logic to);
      if (!(f[0] && f[3])) return c == 8'h00;
      if (c == 8'h00) return 1'b1;
      if (c >= t || to) return 1'b0;
      return p;
   endfunction : edma
   function automatic logic erts(input logic [7:0] m, f, c, t);
      if (m[4] || !m[1]) return 1'b1;
      if (m[5] && f[0]) return c != 8'h00 && c >= t;
      return 1'b0;
   endfunction : erts
   initial begin
      logic [7:0] v, r, m, f, c, t, d;
      logic e, er, dv;
      int i;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(rts_n, 1'b1);
      chk(receive_dma_request, 1'b1);
      for (i = 0; i < 7; i++) begin
         apb(1'b0, 8'(i * 4), 8'h00, r, er);
         chk(r, (i == 5) ? 8'h01 : 8'h00);
         chk(er, i == 6);
      end
      // Random control, trigger and fill sweeps
      for (i = 0; i < 25; i++) begin
         put(8'h00, 1'b0);
         rnd(v);
         m = v & 8'h32;
         f = {4'h0, v[7], 2'h0, v[6]};
         t = 8'(v[5:3]) + 8'h01;
         wr(`OFS_MODEM_CTRL, m);
         wr(`OFS_FIFO_CTRL, f);
         wr(`OFS_RX_TRIGGER, t);
         e = 1'b1;
         repeat (2) begin
            rnd(v);
            c = {5'h0, v[2:0]};
            put(c, v[3]);
            e = edma(e, f, c, t, v[3]);
            chk(receive_dma_request, e);
            chk(rts_n, erts(m, f, c, t));
         end
      end
      // DMA request at fill 4 under the last sweep settings; no drain follows
      put(8'h04, 1'b0);
      e = edma(e, f, 8'h04, t, 1'b0);
      chk(receive_dma_request, e);
      wr(`OFS_INT_MASK, 8'h01);
      @(posedge pclk);
      ring_indicator_in <= 1'b1;
      repeat (6) @(negedge pclk);
      chk(irq, 1'b1);
      rdc(`OFS_MODEM_STAT, 8'h44);
      rdc(`OFS_MODEM_STAT, 8'h40);
      wr(`OFS_INT_STAT, 8'h01);
      put(c, 1'b0);
      chk(irq, 1'b0);
      wr(`OFS_INT_MASK, 8'h00);
      @(posedge pclk);
      ring_indicator_in <= 1'b0;
      repeat (6) @(posedge pclk);
      ring_indicator_in <= 1'b1;
      repeat (6) @(negedge pclk);
      chk(irq, 1'b0);
      rdc(`OFS_INT_STAT, 8'h01);
      strobe_host_inst.rd(1'b0, 1'b0, `IDX_MODEM_STAT, d, dv);
      chk(dv, 1'b0);
      strobe_host_inst.rd(1'b1, 1'b1, `IDX_MODEM_STAT, d, dv);
      chk(dv, 1'b1);
      chk(d, 8'h44);
      strobe_host_inst.rd(1'b0, 1'b1, `IDX_MODEM_STAT, d, dv);
      chk(dv, 1'b1);
      chk(d, 8'h40);
      @(posedge pclk);
      ring_indicator_in <= 1'b0;
      repeat (6) @(posedge pclk);
      rdc(`OFS_MODEM_STAT, 8'h00);
      give_verdict();
   end
endmodule : tb_top
bind serial_element_modem modem_sva #(.CNT_W(CNT_W)) modem_sva_inst (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .chip_select, .data_out, .data_oe_n, .rx_count, .receive_dma_request);
